// *** diag_regs_pkg.sv ***
// constants, field layouts and carrier types for the bridge device and diagnostic control registers
`default_nettype none
package diag_regs_pkg;

   // =====================================================================
   // register map (index = printed offset, byte address = 4 * index)
   // =====================================================================
   localparam int              ADDR_W                   = 10;
   localparam logic [7:0]      ID_INDEX                 = 8'h00;
   localparam logic [7:0]      DEVICE_CONTROL_INDEX     = 8'h92;
   localparam logic [7:0]      DIAGNOSTIC_CONTROL_INDEX = 8'h93;
   localparam logic [1:0]      WORD_ALIGN               = 2'h0;

   // =====================================================================
   // reset values and fixed bits
   // =====================================================================
   localparam logic [7:0]      DEVICE_CONTROL_RESET     = 8'h66;
   localparam logic [7:0]      DIAGNOSTIC_CONTROL_RESET = 8'h60;
   localparam logic [7:0]      DEVICE_ZERO_MASK         = 8'h10;
   localparam logic [7:0]      DIAG_ONE_MASK            = 8'h40;
   localparam logic [31:0]     ID_MASKED_VALUE          = 32'hFFFFFFFF;
   localparam logic [23:0]     UPPER_ZERO               = 24'h000000;

   // =====================================================================
   // timing figures
   // =====================================================================
   localparam logic [6:0]      RETRY_LIMIT_SHORT        = 7'h10;
   localparam logic [6:0]      RETRY_LIMIT_LONG         = 7'h40;
   localparam int              DISCARD_SHORT_EXP        = 10;
   localparam int              DISCARD_LONG_EXP         = 15;
   localparam int              DT_W                     = 16;
   localparam logic [3:0]      CSC_HOST_ROUTE_CODE      = 4'h0;

   // =====================================================================
   // interrupt signalling modes
   // =====================================================================
   typedef enum logic [1:0] {
      INT_PARALLEL_PCI_ONLY  = 2'h0,
      INT_PARALLEL_IRQ_PCI   = 2'h1,
      INT_SERIAL_IRQ_PAR_PCI = 2'h2,
      INT_SERIAL_IRQ_PCI     = 2'h3
   } interrupt_mode_t;

   // =====================================================================
   // register layouts, first field is bit 7
   // =====================================================================
   typedef struct packed {
      logic            socket_power_hold;
      logic            low_voltage_socket_force;
      logic            diag_io_option;
      logic            reserved_zero;
      logic            vendor_test;
      interrupt_mode_t interrupt_signal_select;
      logic            nand_tree_enable;
   } device_control_t;

   typedef struct packed {
      logic            id_read_masking;
      logic            fixed_one;
      logic            card_status_change_route;
      logic            delayed_txn_off;
      logic            retry_latency_long;
      logic            card_discard_timer_select;
      logic            host_discard_timer_select;
      logic            zoom_video_model_select;
   } diagnostic_control_t;

endpackage : diag_regs_pkg
`default_nettype wire

// *** cardbus_bridge_device_diag_regs.sv ***
// device control and diagnostic register bank with the logic they steer
`timescale 1ns/1ps
`default_nettype none

// Function
// - hold bit 7 set refuses socket power-down while the function is in D3
// - bit 6 forces low-voltage socket capability; reset reports capable
// - bit 5 is a read/write diagnostic option resetting to 1
// - bit 4 always reads 0; writes to it change nothing
// - software writes only 0 to bit 3; set shortens interrogation counter
// - bits 2-1 pick interrupt signalling mode; reset value 11 selects serial
// - bit 0 enables NAND-tree chain over input and bidirectional pins only
// - diagnostic bit 7 set makes ID reads all ones, else true values
// - diagnostic bit 6 is read-only and always reads 1
// - diagnostic bit 5 picks which compatibility bits route status changes to host
// - diagnostic bit 4 set disables the delayed transaction mechanism
// - diagnostic bit 3 set lengthens retry latency from 16 to 64 clocks
// - diagnostic bit 2 selects card-side discard timer, 2^10 set, 2^15 clear
// - diagnostic bit 1 selects host-side discard timer, 2^10 set, 2^15 clear
// - diagnostic bit 0 at 0 picks new zoomed video model, 1 legacy
module cardbus_bridge_device_diag_regs
   import diag_regs_pkg::*;
#(
   parameter logic [15:0] VENDOR_ID_VALUE      = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_ID_VALUE      = 16'h5678, // arbitrary value
   parameter int          DISCARD_SHORT_CYCLES = 2 ** DISCARD_SHORT_EXP,
   parameter int          DISCARD_LONG_CYCLES  = 2 ** DISCARD_LONG_EXP,
   parameter int          INTERROGATE_CYCLES   = 4000,
   parameter int          INTERROGATE_SHORT    = 16,
   parameter int          NAND_PINS            = 8,
   parameter logic [7:0]  NAND_PIN_MASK        = 8'hFF
)(
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  psel_in,
   input  wire logic                  penable_in,
   input  wire logic                  pwrite_in,
   input  wire logic [ADDR_W-1:0]     paddr_in,
   input  wire logic [31:0]           pwdata_in,
   input  wire logic [3:0]            pstrb_in,
   output logic                       pready_out,
   output logic [31:0]                prdata_out,
   output logic                       pslverr_out,
   input  wire logic                  function_in_d3_in,
   input  wire logic                  socket_power_down_req_in,
   input  wire logic                  socket_power_up_req_in,
   output logic                       socket_power_on_out,
   output logic                       power_down_refused_out,
   output logic                       interrogate_tick_out,
   input  wire logic [NAND_PINS-1:0]  nand_pins_in,
   output logic                       nand_tree_out,
   input  wire logic                  csc_event_in,
   input  wire logic                  compat_803_bit4_in,
   input  wire logic [3:0]            compat_805_route_in,
   output logic                       csc_to_host_out,
   input  wire logic                  card_dt_start_in,
   input  wire logic                  card_dt_done_in,
   output logic                       card_dt_expired_out,
   input  wire logic                  host_dt_start_in,
   input  wire logic                  host_dt_done_in,
   output logic                       host_dt_expired_out,
   output logic [6:0]                 retry_latency_limit_out,
   output device_control_t            device_control_out,
   output diagnostic_control_t        diagnostic_control_out
);

   // =====================================================================
   // state of the whole block
   // =====================================================================
   // all state in one packed struct
   typedef struct packed {
      device_control_t     dev;
      diagnostic_control_t diag;
      logic [31:0]         rdata;
      logic                slverr;
      logic                socket_on;
      logic                refused;
      logic [DT_W-1:0]     interrogate_cnt;
      logic                interrogate_tick;
      logic                nand_out;
      logic                csc_out;
      logic [DT_W-1:0]     card_cnt;
      logic                card_run;
      logic                card_expired;
      logic [DT_W-1:0]     host_cnt;
      logic                host_run;
      logic                host_expired;
      logic [6:0]          retry_limit;
   } state_t;

   // reset image of the state
   // register fields at their defaults, pulses low
   // socket power off until an up request
   localparam state_t STATE_RESET = '{
      dev:              device_control_t'(DEVICE_CONTROL_RESET),
      diag:             diagnostic_control_t'(DIAGNOSTIC_CONTROL_RESET),
      rdata:            '0,
      slverr:           1'b0,
      socket_on:        1'b0,
      refused:          1'b0,
      interrogate_cnt:  '0,
      interrogate_tick: 1'b0,
      nand_out:         1'b0,
      csc_out:          1'b0,
      card_cnt:         '0,
      card_run:         1'b0,
      card_expired:     1'b0,
      host_cnt:         '0,
      host_run:         1'b0,
      host_expired:     1'b0,
      retry_limit:      RETRY_LIMIT_SHORT
   };

   state_t state_reg;
   state_t state_next;

   // =====================================================================
   // helpers
   // =====================================================================
   // decoding used more than once
   // last count of a discard timer for a select bit
   function automatic logic [DT_W-1:0] discard_last(input logic short_sel);
      if (short_sel)
         discard_last = DT_W'(DISCARD_SHORT_CYCLES - 1);
      else
         discard_last = DT_W'(DISCARD_LONG_CYCLES - 1);
   endfunction : discard_last

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] index);
      // aligned word, low two bits zero
      reg_addr = {index, WORD_ALIGN};
   endfunction : reg_addr

   // one step of a discard timer: run, count, expire once
   function automatic logic [DT_W+1:0] discard_step(
      input logic            enable,
      input logic            start,
      input logic            done,
      input logic            running,
      input logic [DT_W-1:0] count,
      input logic [DT_W-1:0] last
   );
      logic            run_n;
      logic            exp_n;
      logic [DT_W-1:0] cnt_n;
      run_n = running;
      exp_n = 1'b0;
      cnt_n = count;
      // done or disable beats start
      // so a late start cannot revive a cleared timer
      if (!enable || done)
      begin
         run_n = 1'b0;
         cnt_n = '0;
      end
      else if (start)
      begin
         run_n = 1'b1;
         cnt_n = '0;
      end
      // expire once at the last count, then idle
      else if (running)
      begin
         if (count == last)
         begin
            run_n = 1'b0;
            exp_n = 1'b1;
            cnt_n = '0;
         end
         else
            cnt_n = count + DT_W'(1);
      end
      discard_step = {run_n, exp_n, cnt_n};
   endfunction : discard_step

   // apb decode terms
   logic setup_phase;
   logic access_write;
   logic nand_chain;

   // apb phases, slave never inserts wait states
   // read data latched in setup, so prdata_out
   // comes from a flip-flop in the access cycle
   // only strobe lane 0 gates the 8-bit registers
   assign setup_phase  = psel_in && !penable_in;
   assign access_write = psel_in && penable_in && pwrite_in && pstrb_in[0];
   assign pready_out   = psel_in && penable_in;

   // =====================================================================
   // nand tree over input and bidirectional pins only
   // =====================================================================
   always_comb
   begin
      // output-only pins masked out of the chain
      // chain starts at one, each pin folds in once
      nand_chain = 1'b1;
      for (int i = 0; i < NAND_PINS; i++)
      begin
         if (NAND_PIN_MASK[i])
            nand_chain = ~(nand_chain & nand_pins_in[i]);
      end
   end

   // =====================================================================
   // next state
   // =====================================================================
   always_comb
   begin
      logic [DT_W+1:0] card_step;
      logic [DT_W+1:0] host_step;
      logic [DT_W-1:0] interrogate_last;
      state_next = state_reg;
      card_step  = '0;
      host_step  = '0;
      interrogate_last = '0;

      // read data and error captured in the setup cycle
      // unmapped address: error flag and zero data
      if (setup_phase)
      begin
         state_next.slverr = 1'b0;
         if (paddr_in == reg_addr(DEVICE_CONTROL_INDEX))
            state_next.rdata = {UPPER_ZERO, state_reg.dev};
         else if (paddr_in == reg_addr(DIAGNOSTIC_CONTROL_INDEX))
            state_next.rdata = {UPPER_ZERO, state_reg.diag};
         else if (paddr_in == reg_addr(ID_INDEX))
         begin
            if (state_reg.diag.id_read_masking)
               state_next.rdata = ID_MASKED_VALUE;
            else
               state_next.rdata = {DEVICE_ID_VALUE, VENDOR_ID_VALUE};
         end
         else
         begin
            state_next.rdata  = '0;
            state_next.slverr = 1'b1;
         end
      end

      // register writes at the access edge
      // reserved bit forced low, fixed diag bit high
      // id word and unmapped writes change nothing
      if (access_write && paddr_in == reg_addr(DEVICE_CONTROL_INDEX))
         state_next.dev = device_control_t'(pwdata_in[7:0] & ~DEVICE_ZERO_MASK);
      if (access_write && paddr_in == reg_addr(DIAGNOSTIC_CONTROL_INDEX))
         state_next.diag = diagnostic_control_t'(pwdata_in[7:0] | DIAG_ONE_MASK);

      // socket power with hold in D3
      // down request wins over up in one cycle
      // refusal is high one cycle per down request cycle, level kept
      state_next.refused = 1'b0;
      if (socket_power_down_req_in)
      begin
         if (state_reg.dev.socket_power_hold && function_in_d3_in)
            state_next.refused = 1'b1;
         else
            state_next.socket_on = 1'b0;
      end
      else if (socket_power_up_req_in)
         state_next.socket_on = 1'b1;

      // interrogation counter, shortened by the test bit
      // wrap on >= so a switch to short acts at once
      if (state_reg.dev.vendor_test)
         interrogate_last = DT_W'(INTERROGATE_SHORT - 1);
      else
         interrogate_last = DT_W'(INTERROGATE_CYCLES - 1);
      state_next.interrogate_tick = 1'b0;
      if (state_reg.interrogate_cnt >= interrogate_last)
      begin
         state_next.interrogate_cnt  = '0;
         state_next.interrogate_tick = 1'b1;
      end
      else
         state_next.interrogate_cnt = state_reg.interrogate_cnt + DT_W'(1);

      // nand tree output only while enabled
      state_next.nand_out = state_reg.dev.nand_tree_enable && nand_chain;

      // card status change routing to host
      // diagnostic bit 5 picks the compatibility test
      if (state_reg.diag.card_status_change_route)
         state_next.csc_out = csc_event_in && (compat_805_route_in == CSC_HOST_ROUTE_CODE);
      else
         state_next.csc_out = csc_event_in && compat_803_bit4_in;

      // retry latency limit
      // follows the diagnostic bit one cycle later
      if (state_reg.diag.retry_latency_long)
         state_next.retry_limit = RETRY_LIMIT_LONG;
      else
         state_next.retry_limit = RETRY_LIMIT_SHORT;

      // discard timers, idle while delayed transactions are off
      // both timers share the disable bit
      card_step = discard_step(!state_reg.diag.delayed_txn_off, card_dt_start_in, card_dt_done_in,
                               state_reg.card_run, state_reg.card_cnt,
                               discard_last(state_reg.diag.card_discard_timer_select));
      host_step = discard_step(!state_reg.diag.delayed_txn_off, host_dt_start_in, host_dt_done_in,
                               state_reg.host_run, state_reg.host_cnt,
                               discard_last(state_reg.diag.host_discard_timer_select));
      // unpack run, expired and count
      state_next.card_run     = card_step[DT_W+1];
      state_next.card_expired = card_step[DT_W];
      state_next.card_cnt     = card_step[DT_W-1:0];
      state_next.host_run     = host_step[DT_W+1];
      state_next.host_expired = host_step[DT_W];
      state_next.host_cnt     = host_step[DT_W-1:0];
   end

   // =====================================================================
   // state register
   // =====================================================================
   // async reset loads the default image
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         state_reg <= STATE_RESET;
      else
         state_reg <= state_next;
   end

   // =====================================================================
   // outputs
   // =====================================================================
   assign prdata_out              = state_reg.rdata;
   // error shown only in the access phase
   assign pslverr_out             = state_reg.slverr && psel_in && penable_in;
   assign socket_power_on_out     = state_reg.socket_on;
   assign power_down_refused_out  = state_reg.refused;
   assign interrogate_tick_out    = state_reg.interrogate_tick;
   assign nand_tree_out           = state_reg.nand_out;
   assign csc_to_host_out         = state_reg.csc_out;
   assign card_dt_expired_out     = state_reg.card_expired;
   assign host_dt_expired_out     = state_reg.host_expired;
   assign retry_latency_limit_out = state_reg.retry_limit;
   // register contents for the steered logic
   assign device_control_out      = state_reg.dev;
   assign diagnostic_control_out  = state_reg.diag;

endmodule : cardbus_bridge_device_diag_regs
`default_nettype wire

// *** diag_regs_checker_asserts.sv ***
// concurrent checks on the ports of the device and diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module diag_regs_checker
   import diag_regs_pkg::*;
(
   input wire logic                 clk_in,
   input wire logic                 rst_in,
   input wire logic                 psel_in,
   input wire logic                 penable_in,
   input wire logic                 pwrite_in,
   input wire logic [ADDR_W-1:0]    paddr_in,
   input wire logic [31:0]          prdata_out,
   input wire logic                 function_in_d3_in,
   input wire logic                 socket_power_down_req_in,
   input wire logic                 socket_power_on_out,
   input wire logic                 power_down_refused_out,
   input wire logic                 csc_event_in,
   input wire logic                 compat_803_bit4_in,
   input wire logic [3:0]           compat_805_route_in,
   input wire logic                 csc_to_host_out,
   input wire logic                 card_dt_expired_out,
   input wire logic                 host_dt_expired_out,
   input wire logic [6:0]           retry_latency_limit_out,
   input wire device_control_t      device_control_out,
   input wire diagnostic_control_t  diagnostic_control_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // =====================================================================
   // assertions
   // =====================================================================
   AST_HOLD_REFUSE: assert property (socket_power_down_req_in && function_in_d3_in && device_control_out.socket_power_hold
      |=> power_down_refused_out && $stable(socket_power_on_out)) else $error("power down not refused");
   AST_RSVD_ZERO: assert property (psel_in && penable_in && !pwrite_in && paddr_in == 10'h248
      |-> prdata_out == {UPPER_ZERO, device_control_out} && !prdata_out[4]) else $error("device read wrong");
   AST_FIXED_ONE: assert property (diagnostic_control_out.fixed_one) else $error("fixed bit not one");
   AST_ID_MASK: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == 10'h000
      && diagnostic_control_out.id_read_masking |=> prdata_out == ID_MASKED_VALUE) else $error("id not masked");
   AST_RETRY: assert property (retry_latency_limit_out ==
      ($past(diagnostic_control_out.retry_latency_long) ? 7'h40 : 7'h10)) else $error("retry limit wrong");
   AST_CSC: assert property (1'b1 |=> csc_to_host_out == $past(csc_event_in && (diagnostic_control_out.
      card_status_change_route ? compat_805_route_in == 4'h0 : compat_803_bit4_in))) else $error("csc routing wrong");
   AST_DT_OFF: assert property (diagnostic_control_out.delayed_txn_off && $past(diagnostic_control_out.delayed_txn_off)
      |-> !card_dt_expired_out && !host_dt_expired_out) else $error("timer expired while disabled");
   AST_RESET: assert property ($fell(rst_in) |-> device_control_out == DEVICE_CONTROL_RESET
      && diagnostic_control_out == DIAGNOSTIC_CONTROL_RESET) else $error("reset values wrong");

   // main scenarios reached
   COV_REFUSE: cover property (power_down_refused_out);
   COV_CSC: cover property (csc_to_host_out);
   COV_EXPIRE: cover property (card_dt_expired_out && host_dt_expired_out);
endmodule : diag_regs_checker
`default_nettype wire

// *** tb_cardbus_bridge_device_diag_regs.sv ***
// self-checking testbench for the device and diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cardbus_bridge_device_diag_regs;
   import diag_regs_pkg::*;
   localparam logic [9:0] DEV_A = 10'h248;
   localparam logic [9:0] DIAG_A = 10'h24C;
   logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [9:0] paddr_in = 10'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   logic [3:0] pstrb_in = 4'hF, compat_805_route_in = 4'h0;
   logic function_in_d3_in = 1'b0, socket_power_down_req_in = 1'b0, socket_power_up_req_in = 1'b0;
   logic csc_event_in = 1'b0, compat_803_bit4_in = 1'b0, card_dt_start_in = 1'b0, host_dt_start_in = 1'b0;
   logic card_dt_done_in = 1'b0, host_dt_done_in = 1'b0, er;
   logic [7:0] nand_pins_in = 8'h00, d;
   logic pready_out, pslverr_out, socket_power_on_out, power_down_refused_out, interrogate_tick_out;
   logic nand_tree_out, csc_to_host_out, card_dt_expired_out, host_dt_expired_out;
   logic [6:0] retry_latency_limit_out;
   device_control_t device_control_out;
   diagnostic_control_t diagnostic_control_out;
   int mismatches = 0, cmp_count = 0, cn, hn, g;
   logic [15:0] rnd = 16'h592D;

   cardbus_bridge_device_diag_regs #(.DISCARD_SHORT_CYCLES(32), .DISCARD_LONG_CYCLES(64), .INTERROGATE_CYCLES(40))
      i_cardbus_bridge_device_diag_regs (.*);

   always #12.5 clk_in = ~clk_in;

   // =====================================================================
   // helpers
   // =====================================================================
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt

   // expected chain value with every pin included
   function automatic logic nand_exp(input logic [7:0] p);
      logic acc;
      acc = 1'b1;
      for (int i = 0; i < 8; i++) acc = ~(acc & p[i]);
      return acc;
   endfunction : nand_exp

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one apb transfer, waits for pready, ends one edge after release
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] wd, input logic [3:0] s = 4'hF);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= wd;
      pstrb_in <= s;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do
      begin
         @(posedge clk_in);
      end
      while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask : apb

   task automatic reset_dut();
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      chk("device reset", device_control_out, 8'h66);
      chk("diag reset", diagnostic_control_out, 8'h60);
      chk("retry reset", retry_latency_limit_out, 7'h10);
      chk("socket reset", socket_power_on_out, 1'b0);
   endtask : reset_dut

   // interval between two interrogation ticks
   task automatic gap(output int t);
      int n;
      n = 0;
      do begin @(posedge clk_in); #1; n++; end while (!interrogate_tick_out && n < 200);
      t = 0;
      do begin @(posedge clk_in); #1; t++; end while (!interrogate_tick_out && t < 200);
   endtask : gap

   task automatic close_out();
      if (mismatches == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (20000) @(posedge clk_in);
      mismatches++;
      close_out();
   end

   // =====================================================================
   // scenarios
   // =====================================================================
   initial
   begin
      reset_dut();
      apb(0, DEV_A, 0); chk("device read", rd, 32'h66);
      apb(0, DIAG_A, 0); chk("diag read", rd, 32'h60);
      // random register contents, interrupt modes cycle on device writes
      for (int i = 0; i < 16; i++)
      begin
         rnd = nxt(rnd);
         d = {rnd[7:3], i[2:1], rnd[0]};
         apb(1, i[0] ? DIAG_A : DEV_A, {rnd[15:8], rnd, d});
         apb(0, i[0] ? DIAG_A : DEV_A, 0);
         chk("reg readback", rd, i[0] ? (d | 8'h40) : (d & 8'hEF));
         if (i[0]) chk("retry limit", retry_latency_limit_out, d[3] ? 7'h40 : 7'h10);
         else chk("int mode", device_control_out.interrupt_signal_select, d[2:1]);
      end
      apb(1, DEV_A, 32'h66);
      apb(1, DEV_A, 32'h00, 4'h0); apb(0, DEV_A, 0); chk("strobe off", rd, 32'h66);
      apb(1, DIAG_A, 0); apb(0, 10'h000, 0); chk("id true", rd, 32'h56781234);
      apb(1, DIAG_A, 32'h80); apb(0, 10'h000, 0); chk("id masked", rd, 32'hFFFFFFFF);
      apb(0, 10'h100, 0); chk("unmapped err", er, 1'b1); chk("unmapped data", rd, 0);
      apb(1, 10'h000, 32'h5A); chk("id write err", er, 1'b0);
      // socket power: hold and d3 in all four combinations
      for (int k = 0; k < 4; k++)
      begin
         apb(1, DEV_A, {k[1], 7'h06});
         function_in_d3_in <= k[0];
         socket_power_up_req_in <= 1'b1;
         @(posedge clk_in); socket_power_up_req_in <= 1'b0;
         @(posedge clk_in); socket_power_down_req_in <= 1'b1;
         @(posedge clk_in); socket_power_down_req_in <= 1'b0;
         #1 chk("refused", power_down_refused_out, k == 3);
         @(posedge clk_in); #1 chk("socket", socket_power_on_out, k == 3);
      end
      // status change routing table
      for (int k = 0; k < 8; k++)
      begin
         rnd = nxt(rnd);
         apb(1, DIAG_A, {k[2], 5'h00});
         compat_803_bit4_in <= k[0];
         compat_805_route_in <= k[1] ? 4'h0 : {1'b1, rnd[2:0]};
         csc_event_in <= 1'b1;
         @(posedge clk_in); csc_event_in <= 1'b0;
         #1 chk("csc route", csc_to_host_out, k[2] ? k[1] : k[0]);
      end
      // discard timers: every select pair, then disabled
      for (int k = 0; k < 5; k++)
      begin
         apb(1, DIAG_A, k == 4 ? 32'h10 : {k[1:0], 1'b0});
         card_dt_start_in <= 1'b1; host_dt_start_in <= 1'b1;
         cn = 0; hn = 0;
         for (int n = 1; n < 80; n++)
         begin
            @(posedge clk_in); card_dt_start_in <= 1'b0; host_dt_start_in <= 1'b0;
            #1 if (card_dt_expired_out) cn = n;
            if (host_dt_expired_out) hn = n;
         end
         chk("card timer", cn, k == 4 ? 0 : (k[1] ? 33 : 65));
         chk("host timer", hn, k == 4 ? 0 : (k[0] ? 33 : 65));
      end
      apb(1, DEV_A, 32'h06); gap(g); chk("interrogate long", g, 40);
      apb(1, DEV_A, 32'h0E); gap(g); gap(g); chk("interrogate short", g, 16);
      apb(1, DEV_A, 32'h07);
      for (int k = 0; k < 6; k++)
      begin
         rnd = nxt(rnd);
         @(posedge clk_in); nand_pins_in <= rnd[7:0];
         @(posedge clk_in); @(posedge clk_in); #1 chk("nand tree", nand_tree_out, nand_exp(rnd[7:0]));
      end
      apb(1, DEV_A, 32'h06); #1 chk("nand off", nand_tree_out, 1'b0);
      reset_dut();
      close_out();
   end
endmodule : tb_cardbus_bridge_device_diag_regs

bind cardbus_bridge_device_diag_regs diag_regs_checker i_diag_regs_checker (.*);
`default_nettype wire
